// >>> verilog/ccde_pkg.sv
// Shared constants, types and decode helpers for the clear/complement/decrement executor
package ccde_pkg;

   localparam int CCDE_OPC_W = 14;
   localparam int CCDE_DATA_W = 8;
   localparam int CCDE_IDX_W = 7;
   localparam int CCDE_GRP_W = 6;
   localparam int CCDE_CNT_W = 16;

   // Opcode groups held in opcode[13:8]
   localparam logic [5:0] CCDE_GRP_CLR = 6'h01;
   localparam logic [5:0] CCDE_GRP_INV = 6'h09;
   localparam logic [5:0] CCDE_GRP_DEC = 6'h03;
   localparam int CCDE_DEST_BIT = 7;
   localparam logic [13:0] CCDE_OPC_CLRACC = 14'h0103;
   localparam logic [13:0] CCDE_OPC_KICK = 14'h0064;

   localparam logic [7:0] CCDE_ZERO_BYTE = 8'h00;
   localparam logic [7:0] CCDE_ONE_BYTE = 8'h01;

   // APB register map (byte addresses)
   localparam logic [7:0] CCDE_OFS_CTRL = 8'h00;
   localparam logic [7:0] CCDE_OFS_STATUS = 8'h04;
   localparam logic [7:0] CCDE_OFS_ACCUM = 8'h08;
   localparam logic [7:0] CCDE_OFS_COUNT = 8'h0c;
   localparam logic [7:0] CCDE_OFS_LAST = 8'h10;

   // Field positions
   localparam int CCDE_CTRL_EN_BIT = 0;
   localparam int CCDE_ST_ZERO_BIT = 0;
   localparam int CCDE_ST_EXPIRY_BIT = 1;
   localparam int CCDE_ST_SLEEP_BIT = 2;

   // Reset values
   localparam logic CCDE_RST_EXEC_EN = 1'b1;
   localparam logic CCDE_RST_EXPIRY = 1'b1;
   localparam logic CCDE_RST_SLEEP = 1'b1;
   localparam logic CCDE_RST_ZERO = 1'b0;
   localparam logic [7:0] CCDE_RST_ACCUM = 8'h00;

   typedef enum logic [5:0] {
      CCDE_OP_NONE = 6'b000001,
      CCDE_OP_CLEAR_FILE_REG = 6'b000010,
      CCDE_OP_CLEAR_ACCUMULATOR = 6'b000100,
      CCDE_OP_INV = 6'b001000,
      CCDE_OP_DEC = 6'b010000,
      CCDE_OP_KICK = 6'b100000
   } ccde_op_t;

   typedef struct packed {
      logic valid;
      logic [13:0] opcode;
      logic [7:0] operand;
   } ccde_instr_t;

   typedef struct packed {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
   } ccde_wr_t;

   function automatic logic [5:0] ccde_group(input logic [13:0] opc);
      return opc[13:8];
   endfunction

   function automatic logic ccde_dest_file(input logic [13:0] opc);
      return opc[CCDE_DEST_BIT];
   endfunction

endpackage

// >>> verilog/ccde_alu.sv
// Instruction decode and result datapath for the executor
`timescale 1ns/1ps
`default_nettype none
module ccde_alu
   import ccde_pkg::*;
(
   input wire logic [13:0] opcode,
   input wire logic [7:0] operand,
   output ccde_op_t op,
   output logic [7:0] result,
   output logic destFile
);

   always_comb
   begin
      op = CCDE_OP_NONE;
      if (opcode == CCDE_OPC_KICK)
      begin
         op = CCDE_OP_KICK;
      end
      else if (ccde_group(opcode) == CCDE_GRP_CLR && ccde_dest_file(opcode))
      begin
         op = CCDE_OP_CLEAR_FILE_REG;
      end
      else if (opcode == CCDE_OPC_CLRACC)
      begin
         op = CCDE_OP_CLEAR_ACCUMULATOR;
      end
      else if (ccde_group(opcode) == CCDE_GRP_INV)
      begin
         op = CCDE_OP_INV;
      end
      else if (ccde_group(opcode) == CCDE_GRP_DEC)
      begin
         op = CCDE_OP_DEC;
      end
   end

   always_comb
   begin
      result = CCDE_ZERO_BYTE;
      destFile = 1'b0;
      unique case (op)
         CCDE_OP_CLEAR_FILE_REG:
         begin
            result = CCDE_ZERO_BYTE;
            destFile = 1'b1;
         end
         CCDE_OP_INV:
         begin
            result = ~operand;
            destFile = ccde_dest_file(opcode);
         end
         CCDE_OP_DEC:
         begin
            result = operand - CCDE_ONE_BYTE;
            destFile = ccde_dest_file(opcode);
         end
         CCDE_OP_NONE, CCDE_OP_CLEAR_ACCUMULATOR, CCDE_OP_KICK:
         begin
            result = CCDE_ZERO_BYTE;
            destFile = 1'b0;
         end
      endcase
   end

endmodule
`default_nettype wire

// >>> verilog/ccde_exec.sv
// Executor for clear, complement, decrement and guard-kick instructions with APB registers
//
// Functional notes
// - Clear-file writes zero, sets null flag
// - Invert-file yields complement, updates null flag
// - Target bit 0 accumulator, 1 file
// - Decrement-file subtracts one to chosen target
// - Kick resets guard count via the guard clear pulse
// - Kick sets expiry and sleep flags
// - Decrement opcode prefix; null flag from result
`timescale 1ns/1ps
`default_nettype none
module ccde_exec
   import ccde_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   // Instruction from the decoder, operand already read from the register file
   input wire ccde_instr_t instrIn,
   // Other core logic clears the flags (guard timeout, sleep entry)
   input wire logic expiryClr,
   input wire logic sleepClr,
   output ccde_wr_t fileWr,
   output logic [7:0] accum,
   output logic resultNullFlag,
   output logic dogExpiryFlag,
   output logic sleepEntryFlag,
   output logic guardClear,
   output logic instrDone,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   ccde_op_t op;
   logic [7:0] aluResult;
   logic aluDestFile;

   ccde_alu u_alu
   (
      .opcode(instrIn.opcode),
      .operand(instrIn.operand),
      .op(op),
      .result(aluResult),
      .destFile(aluDestFile)
   );

   // Execution state
   ccde_wr_t fileWr_q, fileWr_d;
   logic [7:0] accum_q, accum_d;
   logic zero_q, zero_d;
   logic expiry_q, expiry_d;
   logic sleep_q, sleep_d;
   logic guardClear_q, guardClear_d;
   logic done_q, done_d;
   logic [15:0] count_q, count_d;
   logic [7:0] last_q, last_d;

   // Register interface state
   logic execEn_q, execEn_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;

   logic execGo;
   logic apbAccess;
   logic apbCommit;
   logic apbWrAccum;

   assign execGo = instrIn.valid && execEn_q && (op != CCDE_OP_NONE);
   assign apbAccess = psel && penable;
   // Write commits on the edge where the master sees pready high
   assign apbCommit = apbAccess && pready_q && pwrite;
   assign apbWrAccum = apbCommit && (paddr == CCDE_OFS_ACCUM);

   always_comb
   begin
      fileWr_d = '0;
      accum_d = accum_q;
      zero_d = zero_q;
      expiry_d = expiry_q;
      sleep_d = sleep_q;
      guardClear_d = 1'b0;
      done_d = 1'b0;
      count_d = count_q;
      last_d = last_q;
      // Software load of the accumulator loses to a same-cycle instruction that targets the accumulator
      if (apbWrAccum)
      begin
         accum_d = pwdata[7:0];
      end
      if (execGo)
      begin
         done_d = 1'b1;
         count_d = count_q + 16'h0001;
         if (op == CCDE_OP_KICK)
         begin
            guardClear_d = 1'b1;
         end
         else
         begin
            last_d = aluResult;
            zero_d = (aluResult == CCDE_ZERO_BYTE);
            if (aluDestFile)
            begin
               fileWr_d.en = 1'b1;
               fileWr_d.addr = instrIn.opcode[6:0];
               fileWr_d.data = aluResult;
            end
            else
            begin
               accum_d = aluResult;
            end
         end
      end
      // Set wins over a clear in the same cycle
      if (expiryClr)
      begin
         expiry_d = 1'b0;
      end
      if (sleepClr)
      begin
         sleep_d = 1'b0;
      end
      if (execGo && op == CCDE_OP_KICK)
      begin
         expiry_d = 1'b1;
         sleep_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         fileWr_q <= '0;
         accum_q <= CCDE_RST_ACCUM;
         zero_q <= CCDE_RST_ZERO;
         expiry_q <= CCDE_RST_EXPIRY;
         sleep_q <= CCDE_RST_SLEEP;
         guardClear_q <= 1'b0;
         done_q <= 1'b0;
         count_q <= '0;
         last_q <= CCDE_ZERO_BYTE;
      end
      else
      begin
         fileWr_q <= fileWr_d;
         accum_q <= accum_d;
         zero_q <= zero_d;
         expiry_q <= expiry_d;
         sleep_q <= sleep_d;
         guardClear_q <= guardClear_d;
         done_q <= done_d;
         count_q <= count_d;
         last_q <= last_d;
      end
   end

   // APB: one wait state, then registered answer
   always_comb
   begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = '0;
      execEn_d = execEn_q;
      if (apbAccess && !pready_q)
      begin
         pready_d = 1'b1;
         unique case (paddr)
            CCDE_OFS_CTRL:
            begin
               prdata_d[CCDE_CTRL_EN_BIT] = execEn_q;
            end
            CCDE_OFS_STATUS:
            begin
               prdata_d[CCDE_ST_ZERO_BIT] = zero_q;
               prdata_d[CCDE_ST_EXPIRY_BIT] = expiry_q;
               prdata_d[CCDE_ST_SLEEP_BIT] = sleep_q;
            end
            CCDE_OFS_ACCUM:
            begin
               prdata_d[7:0] = accum_q;
            end
            CCDE_OFS_COUNT:
            begin
               prdata_d[15:0] = count_q;
            end
            CCDE_OFS_LAST:
            begin
               prdata_d[7:0] = last_q;
            end
            default:
            begin
               pslverr_d = 1'b1;
            end
         endcase
         if (pwrite)
         begin
            prdata_d = '0;
         end
      end
      if (apbCommit && paddr == CCDE_OFS_CTRL)
      begin
         execEn_d = pwdata[CCDE_CTRL_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
         execEn_q <= CCDE_RST_EXEC_EN;
      end
      else
      begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         execEn_q <= execEn_d;
      end
   end

   assign fileWr = fileWr_q;
   assign accum = accum_q;
   assign resultNullFlag = zero_q;
   assign dogExpiryFlag = expiry_q;
   assign sleepEntryFlag = sleep_q;
   assign guardClear = guardClear_q;
   assign instrDone = done_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   clear_file_reg_zero_a: assert property (
      execGo && op == CCDE_OP_CLEAR_FILE_REG |=> fileWr.en && fileWr.data == 8'h00 && resultNullFlag)
      else $error("clear-file did not write zero with null flag set");

   invert_value_a: assert property (
      execGo && op == CCDE_OP_INV && instrIn.opcode[7]
      |=> fileWr.en && fileWr.data == ~$past(instrIn.operand)
          && resultNullFlag == ($past(instrIn.operand) == 8'hff))
      else $error("invert-file result or null flag wrong");

   dest_accum_a: assert property (
      execGo && (op == CCDE_OP_INV || op == CCDE_OP_DEC) && !instrIn.opcode[7]
      |=> !fileWr.en && accum == $past(aluResult))
      else $error("target bit 0 did not route to accumulator");

   dec_value_a: assert property (
      execGo && op == CCDE_OP_DEC && instrIn.opcode[7]
      |=> fileWr.data == $past(instrIn.operand) - 8'h01
          && fileWr.addr == $past(instrIn.opcode[6:0]))
      else $error("decrement-file result wrong");

   single_cycle_a: assert property (
      execGo |=> instrDone ##1 !instrDone || $past(execGo))
      else $error("instruction not completed in one cycle");

   kick_clear_a: assert property (
      execGo && op == CCDE_OP_KICK |=> guardClear && !fileWr.en)
      else $error("kick did not clear the guard counter");

   kick_flags_a: assert property (
      execGo && op == CCDE_OP_KICK |=> dogExpiryFlag && sleepEntryFlag)
      else $error("kick did not set expiry and sleep flags");

   dec_zero_a: assert property (
      execGo && op == CCDE_OP_DEC
      |=> resultNullFlag == ($past(instrIn.operand) == 8'h01))
      else $error("decrement null flag wrong");

   clracc_zero_a: assert property (
      execGo && op == CCDE_OP_CLEAR_ACCUMULATOR |=> accum == 8'h00 && resultNullFlag && !fileWr.en)
      else $error("clear-accumulator did not zero the accumulator");

   strobe_idle_a: assert property (
      !execGo |=> !instrDone && !fileWr.en && !guardClear)
      else $error("output strobe without an executed instruction");

   // A kick in the same cycle keeps the flag set, so only a lone clear is checked
   expiry_clear_a: assert property (
      expiryClr && !(execGo && op == CCDE_OP_KICK) |=> !dogExpiryFlag)
      else $error("expiry flag not cleared");

   sleep_clear_a: assert property (
      sleepClr && !(execGo && op == CCDE_OP_KICK) |=> !sleepEntryFlag)
      else $error("sleep flag not cleared");

   apb_answer_a: assert property (
      psel && penable && !pready |=> pready)
      else $error("APB access not answered in one wait state");

   clear_file_reg_cov: cover property (execGo && op == CCDE_OP_CLEAR_FILE_REG);
   dec_zero_cov: cover property (execGo && op == CCDE_OP_DEC && instrIn.operand == 8'h01);
   kick_cov: cover property (execGo && op == CCDE_OP_KICK ##1 expiryClr);
   apb_err_cov: cover property (pready && pslverr);

endmodule
`default_nettype wire

// >>> testbench/ccde_regfile_model.sv
// Register file model that feeds operands and takes write-backs
`timescale 1ns/1ps
`default_nettype none
module ccde_regfile_model
   import ccde_pkg::*;
(
   input wire logic clk_sys,
   input wire ccde_wr_t fileWr,
   input wire logic [6:0] rdIdx,
   output logic [7:0] operand
);
   logic [7:0] mem [128];
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'(i) ^ 8'h5a;
   end
   always @(posedge clk_sys)
   begin
      if (fileWr.en)
         mem[fileWr.addr] <= fileWr.data;
   end
   // Read is combinational, so a write lands one edge after the strobe
   assign operand = mem[rdIdx];
endmodule
`default_nettype wire

// >>> testbench/tb_clear_complement_decrement_exec.sv
// Self-checking bench for the clear/complement/decrement executor
`timescale 1ns/1ps
`default_nettype none
module tb_clear_complement_decrement_exec;
   import ccde_pkg::*;
   typedef struct {logic en; logic [6:0] a; logic [7:0] d; logic [7:0] acc; logic z; logic g;
      int at;} ccde_note_t;
   logic clk_sys = 0;
   logic nrst = 0;
   logic vld = 0;
   logic [13:0] opc = 14'h0000;
   logic expiryClr = 0;
   logic sleepClr = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] operand, accum;
   logic resultNullFlag, dogExpiryFlag, sleepEntryFlag, guardClear, instrDone, pready, pslverr;
   logic [31:0] prdata, rd;
   logic er;
   ccde_instr_t instr;
   ccde_wr_t fileWr;
   ccde_note_t notes[$];
   ccde_note_t m;
   logic [7:0] shadow [128];
   logic [7:0] expAcc = 8'h00;
   logic expZ = 1'b0;
   logic [7:0] expLast = 8'h00;
   int n_errors = 0;
   int compares = 0;
   int ticks = 0;
   int cyc = 0;
   int nExec = 0;
   logic [6:0] i, last;
   logic [13:0] o;

   assign instr = '{vld, opc, operand};
   always #25 clk_sys = ~clk_sys;

   ccde_exec u_dut (.clk_sys(clk_sys), .nrst(nrst), .instrIn(instr), .expiryClr(expiryClr),
      .sleepClr(sleepClr), .fileWr(fileWr), .accum(accum), .resultNullFlag(resultNullFlag),
      .dogExpiryFlag(dogExpiryFlag), .sleepEntryFlag(sleepEntryFlag), .guardClear(guardClear),
      .instrDone(instrDone), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ccde_regfile_model u_rf (.clk_sys(clk_sys), .fileWr(fileWr), .rdIdx(opc[6:0]),
      .operand(operand));

   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", s, exp, seen);
      end
   endtask

   task automatic close_out();
      if (n_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Presents one instruction; the expected outcome is noted only if it should execute
   task automatic issue(input logic [13:0] op, input logic take);
      ccde_note_t n;
      logic [7:0] v, r;
      @(posedge clk_sys);
      vld <= 1'b1;
      opc <= op;
      if (!take)
         return;
      v = shadow[op[6:0]];
      r = (op[13:8] == CCDE_GRP_INV) ? ~v : (op[13:8] == CCDE_GRP_DEC) ? v - 8'h01 : 8'h00;
      n = '{1'b0, 7'h00, 8'h00, expAcc, expZ, 1'b0, ticks + 2};
      if (op == CCDE_OPC_KICK)
         n.g = 1'b1;
      else if (op[CCDE_DEST_BIT])
      begin
         n.en = 1'b1;
         n.a = op[6:0];
         n.d = r;
         shadow[op[6:0]] = r;
      end
      else
         expAcc = r;
      if (op != CCDE_OPC_KICK)
      begin
         expZ = (r == 8'h00);
         expLast = r;
      end
      n.acc = expAcc;
      n.z = expZ;
      nExec++;
      notes.push_back(n);
   endtask

   task automatic idle();
      @(posedge clk_sys);
      vld <= 1'b0;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Request held until the rising edge that samples pready high
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(negedge clk_sys)
   begin
      ticks++;
      if (instrDone === 1'b1)
      begin
         if (notes.size() == 0)
            chk("unexpected done", 1, 0);
         else
         begin
            m = notes.pop_front();
            chk("done time", ticks, m.at);
            chk("file write", fileWr, {m.en, m.a, m.d});
            chk("accum", accum, m.acc);
            chk("zero flag", resultNullFlag, m.z);
            chk("guard clear", guardClear, m.g);
         end
      end
   end

   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_errors++;
         close_out();
      end
   end

   initial
   begin
      void'($urandom(29));
      for (int k = 0; k < 128; k++)
         shadow[k] = 8'(k) ^ 8'h5a;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      apb(1'b0, CCDE_OFS_STATUS, 32'h0);
      chk("status reset", rd, 32'h6);
      chk("status err", er, 32'h0);
      @(posedge clk_sys);
      expiryClr <= 1'b1;
      sleepClr <= 1'b1;
      @(posedge clk_sys);
      expiryClr <= 1'b0;
      sleepClr <= 1'b0;
      @(negedge clk_sys);
      chk("flags cleared", {dogExpiryFlag, sleepEntryFlag}, 0);
      // Kick and clear in one cycle: the set must win
      issue(CCDE_OPC_KICK, 1'b1);
      expiryClr <= 1'b1;
      sleepClr <= 1'b1;
      idle();
      expiryClr <= 1'b0;
      sleepClr <= 1'b0;
      @(negedge clk_sys);
      chk("flags after kick", {dogExpiryFlag, sleepEntryFlag}, 32'h3);
      // Zero, wrap below zero, ignored neighbour code, then back to zero
      issue({CCDE_GRP_CLR, 1'b1, 7'h05}, 1'b1);
      issue(CCDE_OPC_KICK, 1'b1);
      issue({CCDE_GRP_DEC, 1'b1, 7'h05}, 1'b1);
      issue(14'h0105, 1'b0);
      issue({CCDE_GRP_INV, 1'b1, 7'h05}, 1'b1);
      issue(CCDE_OPC_CLRACC, 1'b1);
      issue({CCDE_GRP_DEC, 1'b0, 7'h5b}, 1'b1);
      last = 7'h5b;
      // Back to back; never the index just written, as the file write lags a cycle
      repeat (250)
      begin
         i = 7'($urandom);
         if (i == last)
            i = i + 7'h01;
         last = i;
         case ($urandom % 5)
            0: o = {CCDE_GRP_CLR, 1'b1, i};
            1: o = CCDE_OPC_CLRACC;
            2: o = {CCDE_GRP_INV, 1'($urandom), i};
            3: o = {CCDE_GRP_DEC, 1'($urandom), i};
            default: o = CCDE_OPC_KICK;
         endcase
         issue(o, 1'b1);
      end
      idle();
      apb(1'b1, CCDE_OFS_CTRL, 32'h0);
      issue({CCDE_GRP_DEC, 1'b1, 7'h10}, 1'b0);
      idle();
      apb(1'b1, CCDE_OFS_CTRL, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", er, 32'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b0, CCDE_OFS_CTRL, 32'h0);
      chk("ctrl reg", rd, 32'h1);
      apb(1'b1, CCDE_OFS_ACCUM, 32'h3c);
      apb(1'b0, CCDE_OFS_ACCUM, 32'h0);
      chk("accum reg", rd, 32'h3c);
      apb(1'b0, CCDE_OFS_COUNT, 32'h0);
      chk("exec count", rd, nExec);
      apb(1'b0, CCDE_OFS_LAST, 32'h0);
      chk("last result", rd, expLast);
      repeat (3) idle();
      chk("pending", notes.size(), 0);
      close_out();
   end
endmodule
`default_nettype wire
